// File: verilog/hbridge_drive_fault_control.sv
// Purpose: Gate control of one H-bridge with dead time, chopping and fault handling
// Assumes: All inputs are synchronous to clk_sys; analog comparators are outside
// Notes: Registers are reached over AHB-Lite with no wait states
`timescale 1ns/10ps
module hbridge_drive_fault_control
  import hbridge_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = SLEEP_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Drive inputs from the controller
  input wire logic drive_in_a,
  input wire logic drive_in_b,
  // Comparator and protection indications
  input wire logic chop_threshold,
  input wire logic supply_lockout,
  input wire logic overcurrent_trip,
  input wire logic overtemp_trip,
  // Gate drive of the two half-bridges
  output gate_t bridge_out_a,
  output gate_t bridge_out_b,
  // Power state
  output logic standby,
  output logic supply_on,
  // Open-drain fault pin
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // Shared timer covers wake, off time and retry wait
  localparam int unsigned TMAX = (RETRY_CYCLES > WAKE_CYCLES) ?
    ((RETRY_CYCLES > OFF_CYC) ? RETRY_CYCLES : OFF_CYC) :
    ((WAKE_CYCLES > OFF_CYC) ? WAKE_CYCLES : OFF_CYC);
  localparam int unsigned TW = $clog2(TMAX + 1);
  localparam int unsigned BW = $clog2(BLANK_CYC + 1);
  localparam int unsigned GW = $clog2(GAP_CYC + 1);

  localparam logic [TW-1:0] T_WAKE = TW'(WAKE_CYCLES - 1);
  localparam logic [TW-1:0] T_OFF = TW'(OFF_CYC - 1);
  localparam logic [TW-1:0] T_HALF = TW'(OFF_HALF_CYC);
  localparam logic [TW-1:0] T_RETRY = TW'(RETRY_CYCLES - 1);
  localparam logic [BW-1:0] B_LOAD = BW'(BLANK_CYC - 1);
  localparam logic [GW-1:0] G_LOAD = GW'(GAP_CYC - 1);

  // All state of the block
  typedef struct packed {
    mode_t mode;
    logic [TW-1:0] tmr;
    logic [BW-1:0] blank;
    logic [1:0][GW-1:0] gap;
    gate_t [1:0] gates;
    pair_cmd_t held_cmd;
    logic mixed_en;
    logic fault_oe;
    logic supply_on;
    logic standby;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
  } state_t;

  state_t cur;
  state_t next_cur;

  fault_t flt;
  logic uv_held, oc_held;
  logic sleep_due;
  logic any_in;

  // Input pair to leg commands
  function automatic pair_cmd_t decode_in(input logic a, input logic b);
    pair_cmd_t p;
    p[1] = LEG_OFF;
    p[0] = LEG_OFF;
    if (a && !b) begin
      p[1] = LEG_HIGH;
      p[0] = LEG_LOW;
    end else if (!a && b) begin
      p[1] = LEG_LOW;
      p[0] = LEG_HIGH;
    end else if (a && b) begin
      p[1] = LEG_LOW;
      p[0] = LEG_LOW;
    end
    return p;
  endfunction

  // Opposite polarity of a driving pair
  function automatic pair_cmd_t flip_pair(input pair_cmd_t p);
    pair_cmd_t q;
    q[1] = p[0];
    q[0] = p[1];
    return q;
  endfunction

  // Leg command to gate pair
  function automatic gate_t leg_gates(input leg_cmd_t c);
    gate_t g;
    g.hs = (c == LEG_HIGH);
    g.ls = (c == LEG_LOW);
    return g;
  endfunction

  // True for forward or reverse, where current flows through the sense path
  function automatic logic is_drive(input pair_cmd_t p);
    return (p[1] == LEG_HIGH) || (p[0] == LEG_HIGH);
  endfunction

  // Register read mux for the read path; the write forward patches its result
  function automatic logic [31:0] read_reg(input logic [7:0] a, input state_t s,
                                           input fault_t f);
    logic [31:0] d;
    d = '0;
    if (a == REG_CTRL) begin
      d[CTRL_MIXED_BIT] = s.mixed_en;
    end else if (a == REG_STATUS) begin
      d[ST_MODE_LSB +: 3] = s.mode;
      d[ST_UV_BIT] = f.uv;
      d[ST_OC_BIT] = (s.mode == MODE_OC_WAIT);
      d[ST_THERM_BIT] = f.therm;
      d[ST_STANDBY_BIT] = s.standby;
      d[ST_SUPPLY_BIT] = s.supply_on;
      d[ST_GATE_LSB +: 4] = s.gates;
    end
    return d;
  endfunction

  // Undervoltage deglitch
  persist_filter #(.CYC(UV_DEG_CYC)) u_uv_filter (
    .clk_sys(clk_sys),
    .reset(reset),
    .level(supply_lockout),
    .held(uv_held)
  );

  // Overcurrent deglitch
  persist_filter #(.CYC(OC_DEG_CYC)) u_oc_filter (
    .clk_sys(clk_sys),
    .reset(reset),
    .level(overcurrent_trip),
    .held(oc_held)
  );

  // Idle timer for standby entry; any high input restarts it
  persist_filter #(.CYC(SLEEP_CYCLES)) u_sleep_filter (
    .clk_sys(clk_sys),
    .reset(reset),
    .level(!drive_in_a && !drive_in_b),
    .held(sleep_due)
  );

  // Comparator carries its own hysteresis, so the level is used directly
  assign flt = '{uv: uv_held, oc: oc_held, therm: overtemp_trip};
  assign any_in = drive_in_a || drive_in_b;

  // Mode sequencing, leg control and register bus
  always_comb begin
    pair_cmd_t tgt;
    pair_cmd_t in_cmd;
    gate_t want;
    logic hold_off;
    logic act;
    tgt = decode_in(1'b0, 1'b0);
    in_cmd = decode_in(drive_in_a, drive_in_b);
    want = '0;
    hold_off = flt.uv || flt.therm;
    act = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    next_cur = cur;
    next_cur.tmr = (cur.tmr != '0) ? cur.tmr - 1'b1 : '0;

    // Mode machine
    case (cur.mode)
      MODE_SLEEP: begin
        next_cur.standby = 1'b1;
        if (any_in && !flt.uv) begin
          next_cur.mode = MODE_WAKE;
          next_cur.tmr = T_WAKE;
        end
      end
      MODE_WAKE: begin
        if (cur.tmr == '0) begin
          next_cur.mode = MODE_RUN;
          next_cur.standby = 1'b0;
        end
      end
      MODE_RUN: begin
        tgt = in_cmd;
        if (sleep_due) begin
          next_cur.mode = MODE_SLEEP;
          next_cur.standby = 1'b1;
        end else if (chop_threshold && cur.blank == '0 && is_drive(in_cmd) &&
                     cur.gates == {leg_gates(in_cmd[1]), leg_gates(in_cmd[0])}) begin
          // Blank must have run out before the comparator is trusted
          next_cur.held_cmd = in_cmd;
          next_cur.tmr = T_OFF;
          next_cur.mode = cur.mixed_en ? MODE_CHOP_REV : MODE_CHOP_SLOW;
        end
      end
      MODE_CHOP_REV: begin
        tgt = flip_pair(cur.held_cmd);
        if (cur.tmr == T_HALF) begin
          next_cur.mode = MODE_CHOP_SLOW;
        end
      end
      MODE_CHOP_SLOW: begin
        tgt = decode_in(1'b1, 1'b1);
        if (cur.tmr == '0) begin
          next_cur.mode = MODE_RUN;
        end
      end
      MODE_OC_WAIT: begin
        next_cur.supply_on = 1'b0;
        if (cur.tmr == '0) begin
          next_cur.mode = MODE_RUN;
          next_cur.supply_on = 1'b1;
        end
      end
      default: begin
        next_cur.mode = MODE_SLEEP;
      end
    endcase

    // Overcurrent wins over run, and over chop unless undervoltage or overtemperature ends it; a trip still live when the wait ends re-arms it
    if (flt.oc && cur.mode != MODE_SLEEP && cur.mode != MODE_WAKE &&
        !(cur.mode == MODE_OC_WAIT && cur.tmr != '0)) begin
      next_cur.mode = MODE_OC_WAIT;
      next_cur.tmr = T_RETRY;
      next_cur.supply_on = 1'b0;
      tgt = decode_in(1'b0, 1'b0);
    end else if (cur.mode == MODE_OC_WAIT) begin
      tgt = decode_in(1'b0, 1'b0);
    end

    // Undervoltage and overtemperature end any off cycle and block drive
    if (hold_off) begin
      tgt = decode_in(1'b0, 1'b0);
      if (cur.mode == MODE_CHOP_REV || cur.mode == MODE_CHOP_SLOW) begin
        next_cur.mode = MODE_RUN;
      end
    end

    // Fault pin pulls low in any protection state
    next_cur.fault_oe = flt.uv || flt.therm || (next_cur.mode == MODE_OC_WAIT);

    // Per leg: turn-off is immediate, turn-on waits out the gap
    for (int i = 0; i < 2; i++) begin
      want = leg_gates(tgt[i]);
      if (cur.gates[i] == want) begin
        next_cur.gap[i] = (cur.gap[i] != '0) ? cur.gap[i] - 1'b1 : '0;
      end else if ((cur.gates[i].hs && !want.hs) || (cur.gates[i].ls && !want.ls)) begin
        next_cur.gates[i] = '0;
        next_cur.gap[i] = G_LOAD;
      end else if (cur.gap[i] == '0) begin
        next_cur.gates[i] = want;
      end else begin
        next_cur.gap[i] = cur.gap[i] - 1'b1;
      end
    end

    // Any newly conducting transistor restarts the blank
    if ((next_cur.gates & ~cur.gates) != '0) begin
      next_cur.blank = B_LOAD;
    end else if (cur.blank != '0) begin
      next_cur.blank = cur.blank - 1'b1;
    end

    // Bus write lands in the data phase
    if (cur.wr_pend && cur.wr_addr == REG_CTRL) begin
      next_cur.mixed_en = hwdata[CTRL_MIXED_BIT];
    end
    next_cur.wr_pend = act && hwrite;
    next_cur.wr_addr = {haddr[7:2], 2'b00};

    // Read data is captured in the address phase
    next_cur.rdata = '0;
    if (act && !hwrite) begin
      next_cur.rdata = read_reg({haddr[7:2], 2'b00}, cur, flt);
      // Back-to-back write then read of control sees the new value
      if (cur.wr_pend && cur.wr_addr == REG_CTRL && haddr[7:2] == REG_CTRL[7:2]) begin
        next_cur.rdata[CTRL_MIXED_BIT] = hwdata[CTRL_MIXED_BIT];
      end
    end
    next_cur.ready = 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur <= '0;
      cur.mode <= MODE_SLEEP;
      cur.standby <= 1'b1;
      cur.supply_on <= 1'b1;
      cur.mixed_en <= CTRL_MIXED_RST;
      cur.ready <= 1'b1;
      cur.held_cmd <= '{LEG_OFF, LEG_OFF};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state
  assign bridge_out_a = cur.gates[1];
  assign bridge_out_b = cur.gates[0];
  assign standby = cur.standby;
  assign supply_on = cur.supply_on;
  assign fault_flag_n_oe = cur.fault_oe;
  assign fault_flag_n_o = 1'b0;
  assign hrdata = cur.rdata;
  assign hreadyout = cur.ready;
  assign hresp = 1'b0;

endmodule // hbridge_drive_fault_control

// File: verilog/hbridge_pkg.sv
// Purpose: Shared types and constants for the H-bridge drive and fault control
// Assumes: 125 MHz system clock, one AHB-Lite slave with 32-bit data
// Notes: Times are kept in ns; cycle counts derive from them and the clock rate
package hbridge_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 125;

  // Documented times in ns
  localparam int unsigned GAP_NS = 200;
  localparam int unsigned BLANK_NS = 2000;
  localparam int unsigned OFF_NS = 25000;
  localparam int unsigned UV_DEG_NS = 10000;
  localparam int unsigned OC_DEG_NS = 1500;
  localparam int unsigned SLEEP_NS = 1000000;
  localparam int unsigned WAKE_NS = 40000;
  localparam int unsigned RETRY_NS = 3000000;

  // Least times round up, the wake bound rounds down
  localparam int unsigned GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OFF_CYC = (OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OFF_HALF_CYC = OFF_CYC / 2;
  localparam int unsigned UV_DEG_CYC = (UV_DEG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OC_DEG_CYC = (OC_DEG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLEEP_CYC = (SLEEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_CYC = (WAKE_NS * CLK_MHZ) / 1000;
  localparam int unsigned RETRY_CYC = (RETRY_NS * CLK_MHZ + 999) / 1000;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Control field positions and reset value
  localparam int unsigned CTRL_MIXED_BIT = 0;
  localparam logic CTRL_MIXED_RST = 1'b0;

  // Status field positions
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_UV_BIT = 3;
  localparam int unsigned ST_OC_BIT = 4;
  localparam int unsigned ST_THERM_BIT = 5;
  localparam int unsigned ST_STANDBY_BIT = 6;
  localparam int unsigned ST_SUPPLY_BIT = 7;
  localparam int unsigned ST_GATE_LSB = 8;

  // AHB transfer type bit that marks an active transfer
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;

  // Gate pair of one half-bridge
  typedef struct packed {
    logic hs;
    logic ls;
  } gate_t;

  // What one half-bridge is asked to do
  typedef enum logic [1:0] {LEG_OFF, LEG_HIGH, LEG_LOW} leg_cmd_t;

  // Both legs; index 1 is leg a, index 0 is leg b
  typedef leg_cmd_t [1:0] pair_cmd_t;

  // Protection indications; undervoltage and overcurrent after filtering
  typedef struct packed {
    logic uv;
    logic oc;
    logic therm;
  } fault_t;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_SLEEP, MODE_WAKE, MODE_RUN, MODE_CHOP_REV, MODE_CHOP_SLOW, MODE_OC_WAIT
  } mode_t;

endpackage

// File: verilog/persist_filter.sv
// Purpose: Passes a level only after it has stood high for a set number of cycles
// Assumes: Input is synchronous to clk_sys
// Notes: Output drops in the first cycle the input is low
`timescale 1ns/10ps
module persist_filter #(
  parameter int unsigned CYC = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Filtered level
  input wire logic level,
  output logic held
);

  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic held;
  } filt_t;

  filt_t cur;
  filt_t next_cur;

  // Count consecutive high samples
  always_comb begin
    next_cur = cur;
    if (!level) begin
      next_cur.cnt = '0;
      next_cur.held = 1'b0;
    end else if (!cur.held) begin
      if (cur.cnt == LAST) begin
        next_cur.held = 1'b1;
      end else begin
        next_cur.cnt = cur.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign held = cur.held;

endmodule // persist_filter

// File: tb/hbridge_assertions.sv
// Purpose: Port timing checks for the bridge drive and fault control
// Assumes: Bound into the top module, one clock domain
// Notes: Run counters saturate so long runs never wrap to zero
`timescale 1ns/10ps
module hbridge_checker
  import hbridge_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = 200,
  parameter int unsigned WAKE_CYCLES = 50,
  parameter int unsigned RETRY_CYCLES = 300
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Inputs of the block
  input wire logic drive_in_a,
  input wire logic drive_in_b,
  input wire logic supply_lockout,
  input wire logic overcurrent_trip,
  input wire logic overtemp_trip,
  // Outputs of the block
  input wire gate_t bridge_out_a,
  input wire gate_t bridge_out_b,
  input wire logic standby,
  input wire logic supply_on,
  input wire logic fault_flag_n_oe
);
  logic [3:0] g;
  logic [19:0] uv_n, oc_n, lo_n, off_n, wk_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  assign g = {bridge_out_a, bridge_out_b};
  function automatic logic [19:0] up(input logic c, input logic [19:0] n);
    return c ? n + 20'(n != '1) : 20'h0;
  endfunction
  // Unbroken run length of each cause
  always_ff @(posedge clk_sys) begin
    uv_n <= reset ? 20'h0 : up(supply_lockout, uv_n);
    oc_n <= reset ? 20'h0 : up(overcurrent_trip, oc_n);
    lo_n <= reset ? 20'h0 : up(!drive_in_a && !drive_in_b, lo_n);
    off_n <= reset ? 20'h0 : up(!supply_on, off_n);
    wk_n <= reset ? 20'h0 : up(standby && (drive_in_a || drive_in_b) && !supply_lockout, wk_n);
  end
  a_no_shoot: assert property (!(&bridge_out_a) && !(&bridge_out_b))
    else $error("Both transistors of one leg on");
  a_leg_gap: assert property ($fell(bridge_out_a.hs) |=> !bridge_out_a.ls [*8])
    else $error("Leg a low side on inside the gap");
  a_therm_off: assert property (overtemp_trip [*3] |-> g == 4'h0)
    else $error("Gates on during overtemperature");
  a_fault_pin: assert property (overtemp_trip |-> ##[1:2] fault_flag_n_oe)
    else $error("Fault line not pulled low");
  a_uv_off: assert property (uv_n > UV_DEG_CYC + 2 |-> g == 4'h0)
    else $error("Gates on during undervoltage");
  a_oc_off: assert property (!supply_on && !$past(supply_on) |-> g == 4'h0)
    else $error("Gates on during overcurrent wait");
  a_oc_filter: assert property ($fell(supply_on) |-> oc_n >= OC_DEG_CYC - 1)
    else $error("Overcurrent acted on too soon");
  a_oc_retry: assert property ($rose(supply_on) |->
    off_n >= RETRY_CYCLES - 1 && off_n <= RETRY_CYCLES + 2)
    else $error("Retry wait has wrong length");
  a_sleep_entry: assert property ($rose(standby) |-> lo_n >= SLEEP_CYCLES - 2)
    else $error("Standby entered too early");
  a_wake_time: assert property (wk_n <= WAKE_CYCLES + 4)
    else $error("Wake took too long");
  c_wake: cover property ($fell(standby));
  c_oc: cover property ($fell(supply_on));
  c_fault: cover property ($rose(fault_flag_n_oe));
  c_brake: cover property (g == 4'h5);
endmodule // hbridge_checker

bind hbridge_drive_fault_control hbridge_checker #(
  .SLEEP_CYCLES(SLEEP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES), .RETRY_CYCLES(RETRY_CYCLES)
) hbridge_checker_i (
  .clk_sys(clk_sys), .reset(reset), .drive_in_a(drive_in_a), .drive_in_b(drive_in_b),
  .supply_lockout(supply_lockout), .overcurrent_trip(overcurrent_trip),
  .overtemp_trip(overtemp_trip), .bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b),
  .standby(standby), .supply_on(supply_on), .fault_flag_n_oe(fault_flag_n_oe)
);

// File: tb/drive_ctrl_model.sv
// Purpose: Controller model driving the two bridge inputs
// Assumes: The bench sets the wanted state one edge ahead
// Notes: Static levels only; the bench holds each level for at least 81 clock cycles
`timescale 1ns/10ps
module drive_ctrl_model (
  // Clock
  input wire logic clk_sys,
  // Wanted state, bit 1 is leg a
  input wire logic [1:0] cmd,
  // Drive inputs of the bridge
  output logic drive_in_a = 1'b0,
  output logic drive_in_b = 1'b0
);
  // Coast holds both low, which is also the standby level
  always @(posedge clk_sys) begin
    drive_in_a <= cmd[1];
    drive_in_b <= cmd[0];
  end
endmodule // drive_ctrl_model

// File: tb/hbridge_drive_fault_control_tb.sv
// Purpose: Self-checking bench for the bridge drive and fault control
// Assumes: Short sleep, wake and retry counts set at the instance
// Notes: Expected pin states queue up and are compared at the next falling edge
`timescale 1ns/10ps
module hbridge_drive_fault_control_tb;
  import hbridge_pkg::*;
  localparam int unsigned SLP = 200;
  localparam int unsigned WK = 50;
  localparam int unsigned RTY = 300;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [1:0] cmd = 2'h0;
  logic chop_threshold = 1'b0;
  logic supply_lockout = 1'b0;
  logic overcurrent_trip = 1'b0;
  logic overtemp_trip = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic dph = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic drive_in_a, drive_in_b, standby, supply_on, fault_flag_n_o, fault_flag_n_oe;
  logic fault_pin, hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic [6:0] pins;
  gate_t bridge_out_a, bridge_out_b;
  logic [6:0] pin_q[$];
  logic [31:0] rd_q[$];
  logic [1:0] step_c[4] = '{2'h1, 2'h3, 2'h2, 2'h3};
  logic [3:0] step_g[4] = '{4'h6, 4'h5, 4'h9, 4'h5};
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int unsigned seed;

  // Pull-up on the open-drain fault line; the lone slave closes its own bus
  assign fault_pin = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  assign hready = hreadyout;
  assign pins = {bridge_out_a, bridge_out_b, standby, supply_on, fault_pin};
  always #4 clk_sys = ~clk_sys;

  drive_ctrl_model drive_ctrl_model_i (.clk_sys(clk_sys), .cmd(cmd),
    .drive_in_a(drive_in_a), .drive_in_b(drive_in_b));
  hbridge_drive_fault_control #(.SLEEP_CYCLES(SLP), .WAKE_CYCLES(WK), .RETRY_CYCLES(RTY))
  hbridge_drive_fault_control_i (.clk_sys(clk_sys), .reset(reset),
    .drive_in_a(drive_in_a), .drive_in_b(drive_in_b), .chop_threshold(chop_threshold),
    .supply_lockout(supply_lockout), .overcurrent_trip(overcurrent_trip),
    .overtemp_trip(overtemp_trip), .bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b),
    .standby(standby), .supply_on(supply_on), .fault_flag_n_o(fault_flag_n_o),
    .fault_flag_n_oe(fault_flag_n_oe), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic want(input logic [3:0] g, input logic s, input logic on, input logic f);
    pin_q.push_back({g, s, on, f});
  endtask
  task automatic cmp_pins(input logic [6:0] e);
    cmp_count++;
    if (pins !== e) begin
      miscompares++;
      $display("ERROR pins expected %b seen %b", e, pins);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] e);
    cmp_count++;
    if (hrdata !== e || hresp !== 1'b0) begin
      miscompares++;
      $display("ERROR hresp_hrdata expected %h seen %h", {1'b0, e}, {hresp, hrdata});
    end
  endtask
  // Single word transfer; each phase held until hready is seen high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dph <= !w;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    dph <= 1'b0;
  endtask
  task automatic pulse();
    chop_threshold <= 1'b1;
    tick(1);
    chop_threshold <= 1'b0;
  endtask
  task automatic wake_fwd();
    cmd <= 2'h2;
    tick(WK + 10);
    want(4'h9, 1'b0, 1'b1, 1'b1);
  endtask
  // Off cycle after the blanking has long run out
  task automatic chop(input logic [3:0] first, input logic [3:0] second);
    tick(300);
    pulse();
    tick(100);
    want(first, 1'b0, 1'b1, 1'b1);
    tick(OFF_HALF_CYC);
    want(second, 1'b0, 1'b1, 1'b1);
    tick(OFF_HALF_CYC);
    want(4'h9, 1'b0, 1'b1, 1'b1);
  endtask
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Pin states settle well before the falling edge
  always @(negedge clk_sys) begin
    if (pin_q.size() > 0) cmp_pins(pin_q.pop_front());
  end
  // Read data stands only at the edge closing the data phase
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (dph && hready) cmp_rd(rd_q.pop_front());
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    seed = $urandom(30538);
    tick(20);
    reset <= 1'b0;
    tick(1);
    want(4'h0, 1'b1, 1'b1, 1'b1);
    rd_q.push_back(32'h0);
    bus(1'b0, 32'(REG_CTRL), 32'h0);
    rd_q.push_back(32'h0);
    bus(1'b0, 32'h40, 32'h0);
    wake_fwd();
    pulse();
    tick(20);
    want(4'h9, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cmd <= step_c[i];
      tick(320);
      want(step_g[i], 1'b0, 1'b1, 1'b1);
    end
    cmd <= 2'h0;
    tick(40);
    want(4'h0, 1'b0, 1'b1, 1'b1);
    tick(SLP);
    want(4'h0, 1'b1, 1'b1, 1'b1);
    wake_fwd();
    chop(4'h5, 4'h5);
    bus(1'b1, 32'(REG_CTRL), 32'h1);
    rd_q.push_back(32'h1);
    bus(1'b0, 32'(REG_CTRL), 32'h0);
    chop(4'h6, 4'h5);
    rd_q.push_back(32'h982);
    bus(1'b0, 32'(REG_STATUS), 32'h0);
    supply_lockout <= 1'b1;
    tick(100 + $urandom % 1000);
    supply_lockout <= 1'b0;
    tick(2);
    want(4'h9, 1'b0, 1'b1, 1'b1);
    supply_lockout <= 1'b1;
    tick(UV_DEG_CYC + 10);
    want(4'h0, 1'b0, 1'b1, 1'b0);
    supply_lockout <= 1'b0;
    tick(40);
    want(4'h9, 1'b0, 1'b1, 1'b1);
    tick(300);
    pulse();
    tick(50);
    overtemp_trip <= 1'b1;
    tick(10);
    want(4'h0, 1'b0, 1'b1, 1'b0);
    overtemp_trip <= 1'b0;
    tick(40);
    want(4'h9, 1'b0, 1'b1, 1'b1);
    overcurrent_trip <= 1'b1;
    tick(OC_DEG_CYC + 10);
    want(4'h0, 1'b0, 1'b0, 1'b0);
    overcurrent_trip <= 1'b0;
    tick(RTY - 50);
    want(4'h0, 1'b0, 1'b0, 1'b0);
    tick(100);
    want(4'h9, 1'b0, 1'b1, 1'b1);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    want(4'h0, 1'b1, 1'b1, 1'b1);
    rd_q.push_back(32'h0);
    bus(1'b0, 32'(REG_CTRL), 32'h0);
    tick(2);
    close_out();
  end
endmodule // hbridge_drive_fault_control_tb
